// file: shared/mrcu_map.vh
/*
  Constants of the mode register command unit: command codes, register
  addresses, patterns, calibration codes and timing counts.
  Assumes a 50 MHz ref_clk; included by bare name.
*/
`ifndef MRCU_MAP_VH
`define MRCU_MAP_VH

// ****************************************************************
// command decode on ca_rise[3:0]
// ****************************************************************
`define MRCU_OP_MASK 4'hF
`define MRCU_OP_MRW 4'h0
`define MRCU_OP_MRR 4'h8

// ****************************************************************
// mode register addresses
// ****************************************************************
`define MRCU_MR_TEMP 8'h04
`define MRCU_MR_ZQ 8'h0A
`define MRCU_MR_PAT_A 8'h20
`define MRCU_MR_PAT_B 8'h28
`define MRCU_MR_RESET 8'h3F
`define MRCU_MR_DEFAULT 8'h00
`define MRCU_MEM_DEPTH 32
`define MRCU_MEM_AW 5

// ****************************************************************
// calibration patterns, bit 0 is bit time 0
// ****************************************************************
`define MRCU_PAT_A 4'h5
`define MRCU_PAT_B 4'hC

// ****************************************************************
// impedance calibration codes in the write data byte
// ****************************************************************
`define MRCU_ZQ_INIT 8'hFF
`define MRCU_ZQ_LONG 8'hAB
`define MRCU_ZQ_SHORT 8'h56
`define MRCU_ZQ_RESET 8'hC3

// ****************************************************************
// timing
// ****************************************************************
`define MRCU_CLK_KHZ 50000
`define MRCU_RL 3
`define MRCU_TMRR 2
`define MRCU_TMRW 5
`define MRCU_BURST 4
`define MRCU_TSI_MS 32
`define MRCU_TSI_CYC (`MRCU_TSI_MS * `MRCU_CLK_KHZ)
`define MRCU_TZQINIT_CYC 1000
`define MRCU_TZQCL_CYC 400
`define MRCU_TZQCS_CYC 100
`define MRCU_TZQRESET_CYC 3
`define MRCU_TINIT4_CYC 1000
`define MRCU_TIMER_W 24

`endif

// file: testbench/mrcu_chk.sv
/*
  Concurrent checks on the ports of mrcu_top.
  Assumes the constant header is on the include path and clk_en drops only
  while the unit sits in a long initialization period.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mrcu_map.vh"

module mrcu_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic [9:0] ca_rise,
  input wire logic [9:0] ca_fall,
  input wire logic bank_active,
  input wire logic zq_pin_tied_high,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  input wire logic [1:0] burst_beat,
  input wire logic [2:0] unit_state,
  input wire logic mrw_ignored,
  input wire logic zq_current_en,
  input wire logic zq_calibrated,
  input wire logic [7:0] temp_status,
  input wire logic array_undefined
);
  // ****************************************************************
  // command decode as the controller sees it
  // ****************************************************************
  wire logic take = !cs_n && unit_state == 3'h0;
  wire logic [7:0] adr = {ca_fall[1:0], ca_rise[9:4]};
  wire logic rd = take && ca_rise[3:0] == 4'h8;
  wire logic wr = take && ca_rise[3:0] == 4'h0;
  wire logic wr_ok = wr && !bank_active;
  wire logic zq_cmd = wr_ok && adr == `MRCU_MR_ZQ;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_latency;
    (unit_state == 3'h1) [*3];
  endsequence
  sequence s_burst;
    dqs_out && burst_beat == 2'h0 ##1 !dqs_out && burst_beat == 2'h1
    ##1 dqs_out && burst_beat == 2'h2 ##1 !dqs_out && burst_beat == 2'h3;
  endsequence
  sequence s_wr_period;
    (unit_state == 3'h3) [*5] ##1 unit_state == 3'h0;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_read_latency: assert property (rd |=> s_latency ##1 dq_oe)
    else $error("read burst not started after the read latency");
  a_burst_shape: assert property ($rose(dq_oe) |-> s_burst ##1 !dq_oe)
    else $error("read burst is not four toggling beats");
  a_strobe_oe: assert property (dqs_oe == dq_oe)
    else $error("strobe enable differs from data enable");
  a_write_period: assert property (wr_ok && adr != `MRCU_MR_ZQ && adr != `MRCU_MR_RESET
    |=> s_wr_period)
    else $error("write period is not five cycles");
  a_bank_refuse: assert property (wr && bank_active |=> mrw_ignored && unit_state == 3'h0)
    else $error("write with open bank not refused");
  a_readonly_drop: assert property (wr_ok && adr == `MRCU_MR_TEMP |=> mrw_ignored)
    else $error("write to read-only register not dropped");
  a_zq_start: assert property (zq_cmd && ca_fall[9:2] == `MRCU_ZQ_INIT && !zq_pin_tied_high
    && !$past(zq_pin_tied_high, 4) |=> zq_current_en && unit_state == 3'h5)
    else $error("calibration did not start");
  a_zq_tied: assert property (zq_cmd && zq_pin_tied_high && $past(zq_pin_tied_high, 4)
    |=> mrw_ignored && !zq_current_en)
    else $error("calibration ran with pin tied high");
  a_zq_idle_off: assert property (unit_state == 3'h0 |-> !zq_current_en)
    else $error("calibration current on while idle");
  a_zq_done: assert property ($fell(zq_current_en) |-> zq_calibrated)
    else $error("calibration ended without done status");
  a_reset_entry: assert property (wr_ok && adr == `MRCU_MR_RESET
    |=> unit_state == 3'h4 && array_undefined)
    else $error("write reset did not enter initialization");
  a_temp_field: assert property (temp_status[7:3] == 5'h00)
    else $error("temperature status upper bits set");
endmodule
`default_nettype wire

// file: testbench/mrcu_ctrl_model.sv
/*
  Behavioural memory controller driving the command/address bus.
  Assumes the bench calls its tasks; drives 1 ns after the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module mrcu_ctrl_model (
  input wire logic ref_clk,
  input wire logic [2:0] unit_state,
  output var logic cs_n,
  output var logic [9:0] ca_rise,
  output var logic [9:0] ca_fall
);
  initial begin
    cs_n = 1'b1;
    ca_rise = 10'h3FF;
    ca_fall = 10'h3FF;
  end

  // only deselect until the unit is idle
  task automatic wait_idle(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 3000 && !ok; i++) begin
      @(posedge ref_clk);
      #1;
      ok = (unit_state === 3'h0);
    end
  endtask

  task automatic cmd(input logic rd, input logic [7:0] adr, input logic [7:0] dat);
    repeat ($urandom_range(2)) begin
      @(posedge ref_clk);
      #1;
    end
    cs_n = 1'b0;
    ca_rise = {adr[5:0], rd ? 4'h8 : 4'h0};
    ca_fall = {dat, adr[7:6]};
    @(posedge ref_clk);
    #1;
    // a deselected bus must not show a stale copy of the command
    cs_n = 1'b1;
    ca_rise = ~ca_rise;
    ca_fall = ~ca_fall;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
  Self-checking bench for mrcu_top with a controller model and a bound checker.
  Assumes a 50 MHz clock and shortened sensor and initialization counts.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mrcu_map.vh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic bank_active = 1'b0;
  logic [2:0] temp_sensor_code = 3'h0;
  logic zq_pin_tied_high = 1'b0;
  wire logic cs_n;
  wire logic [9:0] ca_rise, ca_fall;
  wire logic [15:0] dq_out;
  wire logic dq_oe, dqs_out, dqs_oe, mrw_ignored, zq_current_en, zq_calibrated, array_undefined;
  wire logic [1:0] burst_beat;
  wire logic [2:0] unit_state;
  wire logic [7:0] temp_status;
  int n_mismatch = 0;
  int compares = 0;
  int n_ign = 0;
  int exp_ign = 0;
  int seed;
  logic ok;
  logic [15:0] beats[$];
  logic [7:0] shadow [256];
  logic [7:0] wdat;
  logic [7:0] rlist [9] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h04, 8'h20, 8'h28, 8'h30};
  logic [7:0] zq_code [4] = '{`MRCU_ZQ_INIT, `MRCU_ZQ_RESET, `MRCU_ZQ_LONG, `MRCU_ZQ_SHORT};
  logic zq_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (dq_oe === 1'b1) beats.push_back(dq_out);
    if (mrw_ignored === 1'b1) n_ign++;
  end

  // short counts keep the run brief
  mrcu_top #(.TSI_CYC(24'h000032), .TINIT4_CYC(24'h000014)) dut (.ref_clk(ref_clk),
    .rst(rst), .clk_en(clk_en), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
    .bank_active(bank_active), .temp_sensor_code(temp_sensor_code),
    .zq_pin_tied_high(zq_pin_tied_high), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .burst_beat(burst_beat), .unit_state(unit_state),
    .mrw_ignored(mrw_ignored), .zq_current_en(zq_current_en), .zq_calibrated(zq_calibrated),
    .temp_status(temp_status), .array_undefined(array_undefined));
  mrcu_ctrl_model ctrl (.ref_clk(ref_clk), .unit_state(unit_state), .cs_n(cs_n),
    .ca_rise(ca_rise), .ca_fall(ca_fall));

  // ****************************************************************
  // expectation and bus helpers
  // ****************************************************************
  function automatic logic [15:0] exp_beat(input logic [7:0] adr, input int k);
    if (adr == `MRCU_MR_PAT_A) return {16{k[0] == 1'b0}};
    if (adr == `MRCU_MR_PAT_B) return {16{k >= 2}};
    if (k != 0) return 16'h0000;
    if (adr == `MRCU_MR_TEMP) return {13'h0000, temp_sensor_code};
    return {8'h00, shadow[adr]};
  endfunction

  task automatic end_of_test();
    $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic fin_wait();
    ctrl.wait_idle(ok);
    if (!ok) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task automatic send(input logic rd, input logic [7:0] adr, input logic [7:0] dat);
    fin_wait();
    ctrl.cmd(rd, adr, dat);
    fin_wait();
  endtask

  task automatic chk_read(input logic [7:0] adr);
    beats.delete();
    send(1'b1, adr, 8'($urandom));
    `CHK(beats.size(), 4)
    for (int k = 0; k < 4; k++) `CHK(beats[k], exp_beat(adr, k))
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = $urandom(76);
    temp_sensor_code = 3'($urandom);
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK(unit_state, 3'h0)
    `CHK(zq_calibrated, 1'b0)
    repeat (60) @(posedge ref_clk);
    #1 `CHK(temp_status, {5'h00, temp_sensor_code})
    $display("test reset and sensor done");
    for (int i = 0; i < 6; i++) begin
      wdat = 8'($urandom);
      // an open bank must make the write bounce
      bank_active = 1'b1;
      send(1'b0, rlist[i], ~wdat);
      bank_active = 1'b0;
      send(1'b0, rlist[i], wdat);
      exp_ign += (i == 5) ? 2 : 1;
      if (i < 5) shadow[rlist[i]] = wdat;
    end
    `CHK(n_ign, exp_ign)
    for (int i = 0; i < 9; i++) begin
      // pattern and reserved reads with banks idle, others at random
      bank_active = (rlist[i] < 8'h20) ? 1'($urandom) : 1'b0;
      chk_read(rlist[i]);
    end
    bank_active = 1'b0;
    $display("test register access done");
    // each calibration code issued in turn, done status checked after each
    for (int i = 0; i < 4; i++) begin
      send(1'b0, `MRCU_MR_ZQ, zq_code[i]);
      `CHK(zq_calibrated, zq_exp[i])
    end
    zq_pin_tied_high = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 send(1'b0, `MRCU_MR_ZQ, `MRCU_ZQ_RESET);
    `CHK(zq_calibrated, 1'b1)
    `CHK(n_ign, exp_ign + 1)
    zq_pin_tied_high = 1'b0;
    $display("test impedance calibration done");
    ctrl.cmd(1'b0, `MRCU_MR_RESET, 8'h00);
    `CHK(array_undefined, 1'b1)
    // a frozen clock enable must hold the initialization period
    clk_en = 1'b0;
    repeat (25) @(posedge ref_clk);
    #1 `CHK(unit_state, 3'h4)
    clk_en = 1'b1;
    fin_wait();
    `CHK(array_undefined, 1'b0)
    foreach (shadow[i]) shadow[i] = 8'h00;
    chk_read(8'h01);
    chk_read(8'h11);
    $display("test write reset done");
    end_of_test();
  end
endmodule

bind mrcu_top mrcu_chk chk (.ref_clk, .rst, .cs_n, .ca_rise, .ca_fall, .bank_active,
  .zq_pin_tied_high, .dq_oe, .dqs_out, .dqs_oe, .burst_beat, .unit_state, .mrw_ignored,
  .zq_current_en, .zq_calibrated, .temp_status, .array_undefined);
`default_nettype wire

// file: verilog/mrcu_sync3.v
/*
  Three-stage synchroniser for pin inputs of any width.
  Assumes one clock domain; the output follows once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none

module mrcu_sync3 #(
  parameter W = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] level_out
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end else if (clk_en) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/mrcu_timer.v
/*
  Loadable down counter giving a busy level and a one-cycle done pulse.
  Assumes load values of at least one; a load wins over counting.
*/
`timescale 1ns/1ns
`default_nettype none

module mrcu_timer #(
  parameter W = 24
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire load,
  input wire [W-1:0] load_val,
  output wire busy,
  output reg done
);

  reg [W-1:0] count_reg;

  assign busy = (count_reg != {W{1'b0}});

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= {W{1'b0}};
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        count_reg <= load_val;
      end else if (busy) begin
        count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        done <= (count_reg == {{(W-1){1'b0}}, 1'b1});
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/mrcu_top.v
/*
  Device-side mode register command unit: decodes register reads and writes
  from the command/address bus, returns register data and calibration patterns,
  runs the write-reset, impedance calibration and temperature status update.
  Assumes ca_rise/ca_fall are both halves of one command captured on ref_clk,
  bank_active comes from the bank logic on the same clock, and the sensor code
  and calibration pin level arrive from outside the clock domain.
*/
// How it works
// - register 4 returns the temperature sensor code in bits 2 to 0
// - register 4 is refreshed internally at most 32 ms apart
// - device tolerates 2 degrees beyond range while controller reacts
// - register 32 returns 1,0,1,0 and register 40 returns 0,0,1,1
// - pattern drives every line of every byte lane during the burst
// - write decoded with select and CA0-CA3 low; address and data fields
// - writes to read-only registers change nothing
// - register read accepted with banks active, bank state kept
// - write-reset restores defaults and runs auto-initialization
// - four calibration commands: init, reset, long and short
// - calibration pin current path is switched off after calibration
// - calibration pin tied to supply makes calibration commands ignored
// - read decoded with select, CA0-CA2 low and CA3 high
// - read period 2 clocks, four-beat burst, strobes toggle throughout; the unit takes the next command only 8 clocks after a read
// - ordinary register data on lines 0 to 7 of the first beat only
// - reserved or write-only register reads return undefined data
`timescale 1ns/1ns
`default_nettype none
`include "mrcu_map.vh"

module mrcu_top #(
  parameter [23:0] TSI_CYC = `MRCU_TSI_CYC,
  parameter [23:0] TINIT4_CYC = `MRCU_TINIT4_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire cs_n,
  input wire [9:0] ca_rise,
  input wire [9:0] ca_fall,
  input wire bank_active,
  input wire [2:0] temp_sensor_code,
  input wire zq_pin_tied_high,
  output reg [15:0] dq_out,
  output reg dq_oe,
  output reg dqs_out,
  output reg dqs_oe,
  output reg [1:0] burst_beat,
  output reg [2:0] unit_state,
  output reg mrw_ignored,
  output reg zq_current_en,
  output reg zq_calibrated,
  output reg [7:0] temp_status,
  output reg array_undefined
);

  // ****************************************************************
  // states and local constants
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RD_WAIT = 3'd1;
  localparam [2:0] ST_RD_BURST = 3'd2;
  localparam [2:0] ST_WR_BUSY = 3'd3;
  localparam [2:0] ST_RESETTING = 3'd4;
  localparam [2:0] ST_ZQ_CAL = 3'd5;
  // integer forms are cut to width on purpose where they are used
  localparam integer TMRW_I = `MRCU_TMRW - 1;
  localparam integer RL_I = `MRCU_RL - 1;
  localparam integer LAST_I = `MRCU_BURST - 1;
  localparam [23:0] TMRW_LOAD = TMRW_I[23:0];
  localparam [1:0] RL_LOAD = RL_I[1:0];
  localparam [1:0] LAST_BEAT = LAST_I[1:0];
  localparam integer ZQINIT_I = `MRCU_TZQINIT_CYC;
  localparam integer ZQCL_I = `MRCU_TZQCL_CYC;
  localparam integer ZQCS_I = `MRCU_TZQCS_CYC;
  localparam integer ZQRST_I = `MRCU_TZQRESET_CYC;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [2:0] sensor_sync;
  wire zq_tied_sync;

  mrcu_sync3 #(.W(3)) u_sensor_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(temp_sensor_code),
    .level_out(sensor_sync)
  );

  mrcu_sync3 #(.W(1)) u_zq_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(zq_pin_tied_high),
    .level_out(zq_tied_sync)
  );

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire [7:0] cmd_addr;
  wire [7:0] cmd_data;
  wire is_mrw;
  wire is_mrr;

  assign is_mrw = !cs_n && ((ca_rise[3:0] & `MRCU_OP_MASK) == `MRCU_OP_MRW);
  assign is_mrr = !cs_n && ((ca_rise[3:0] & `MRCU_OP_MASK) == `MRCU_OP_MRR);
  assign cmd_addr = {ca_fall[1:0], ca_rise[9:4]};
  assign cmd_data = ca_fall[9:2];

  // chosen writable set; everything else below the depth is read-only
  function is_writable;
    input [7:0] a;
    begin
      is_writable = (a == 8'h01) || (a == 8'h02) || (a == 8'h03) ||
        (a == 8'h10) || (a == 8'h11);
    end
  endfunction

  // ****************************************************************
  // shared period timer and temperature interval timer
  // ****************************************************************
  reg tmr_load;
  reg [23:0] tmr_val;
  wire tmr_busy;
  wire tmr_done;
  wire tsi_busy;
  wire tsi_done;

  mrcu_timer #(.W(`MRCU_TIMER_W)) u_period (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  mrcu_timer #(.W(`MRCU_TIMER_W)) u_tsi (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .load(!tsi_busy),
    .load_val(TSI_CYC - 24'h000001),
    .busy(tsi_busy),
    .done(tsi_done)
  );

  // ****************************************************************
  // state and storage
  // ****************************************************************
  reg [2:0] state_next;
  reg [7:0] rd_addr_reg;
  reg [1:0] lat_reg;
  reg [1:0] beat_reg;
  reg [7:0] mem_reg [0:`MRCU_MEM_DEPTH-1];
  reg [1:0] zq_kind_reg;
  integer i;
  wire [2:0] state_reg_w;
  reg zq_code_ok;
  reg [23:0] zq_len;
  reg [1:0] zq_kind;

  // tmr_load/tmr_val follow the command taken in idle
  always @* begin
    state_next = state_reg_w;
    tmr_load = 1'b0;
    tmr_val = TMRW_LOAD;
    case (state_reg_w)
      ST_IDLE: begin
        // read taken whatever the bank state
        if (is_mrr) begin
          state_next = ST_RD_WAIT;
        end else if (is_mrw && !bank_active) begin
          tmr_load = 1'b1;
          if (cmd_addr == `MRCU_MR_RESET) begin
            state_next = ST_RESETTING;
            tmr_val = TINIT4_CYC;
          end else if (cmd_addr == `MRCU_MR_ZQ && !zq_tied_sync && zq_code_ok) begin
            state_next = ST_ZQ_CAL;
            tmr_val = zq_len;
          end else begin
            state_next = ST_WR_BUSY;
          end
        end
      end
      ST_RD_WAIT: begin
        if (lat_reg == 2'd0) begin
          state_next = ST_RD_BURST;
        end
      end
      ST_RD_BURST: begin
        if (beat_reg == LAST_BEAT) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_BUSY, ST_RESETTING, ST_ZQ_CAL: begin
        // back to idle when the period ends
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign state_reg_w = unit_state;

  // ****************************************************************
  // calibration code selection
  // ****************************************************************
  // data byte selects the calibration kind
  always @* begin
    zq_code_ok = 1'b1;
    zq_len = ZQINIT_I[23:0];
    zq_kind = 2'd0;
    case (cmd_data)
      `MRCU_ZQ_INIT: begin
        zq_kind = 2'd0;
      end
      `MRCU_ZQ_LONG: begin
        zq_len = ZQCL_I[23:0];
        zq_kind = 2'd1;
      end
      `MRCU_ZQ_SHORT: begin
        zq_len = ZQCS_I[23:0];
        zq_kind = 2'd2;
      end
      `MRCU_ZQ_RESET: begin
        zq_len = ZQRST_I[23:0];
        zq_kind = 2'd3;
      end
      default: begin
        zq_code_ok = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // read data per beat
  // ****************************************************************
  reg [15:0] beat_data;
  reg [7:0] mr_val;
  reg [1:0] next_beat;
  wire [3:0] pat_a_w = `MRCU_PAT_A;
  wire [3:0] pat_b_w = `MRCU_PAT_B;

  always @* begin
    next_beat = (state_reg_w == ST_RD_BURST) ? beat_reg + 2'd1 : 2'd0;
    mr_val = 8'h00;
    beat_data = 16'h0000;
    if (rd_addr_reg == `MRCU_MR_TEMP) begin
      mr_val = temp_status;
    end else if (rd_addr_reg < `MRCU_MEM_DEPTH) begin
      mr_val = mem_reg[rd_addr_reg[`MRCU_MEM_AW-1:0]];
    end
    if (rd_addr_reg == `MRCU_MR_PAT_A) begin
      beat_data = {16{pat_a_w[next_beat]}};
    end else if (rd_addr_reg == `MRCU_MR_PAT_B) begin
      beat_data = {16{pat_b_w[next_beat]}};
    end else if (rd_addr_reg < `MRCU_MEM_DEPTH && next_beat == 2'd0) begin
      // first beat, low byte only; others read as zero
      beat_data = {8'h00, mr_val};
    end
  end

  // ****************************************************************
  // sequential logic
  // ****************************************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unit_state <= ST_IDLE;
      rd_addr_reg <= 8'h00;
      lat_reg <= 2'd0;
      beat_reg <= 2'd0;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
      burst_beat <= 2'd0;
      mrw_ignored <= 1'b0;
      zq_current_en <= 1'b0;
      zq_calibrated <= 1'b0;
      zq_kind_reg <= 2'd0;
      temp_status <= 8'h00;
      array_undefined <= 1'b0;
      for (i = 0; i < `MRCU_MEM_DEPTH; i = i + 1) begin
        mem_reg[i] <= `MRCU_MR_DEFAULT;
      end
    end else if (clk_en) begin
      unit_state <= state_next;
      mrw_ignored <= 1'b0;
      // register 4 takes the sensor code on each tick
      // code 011 marks the extended range; the margin itself is analog
      if (tsi_done) begin
        temp_status <= {5'h00, sensor_sync};
      end
      if (unit_state == ST_IDLE && is_mrr) begin
        rd_addr_reg <= cmd_addr;
        lat_reg <= RL_LOAD;
      end
      if (unit_state == ST_RD_WAIT) begin
        lat_reg <= lat_reg - 2'd1;
      end
      // strobes toggle each beat of the burst
      if (state_next == ST_RD_BURST) begin
        beat_reg <= next_beat;
        burst_beat <= next_beat;
        dq_out <= beat_data;
        dq_oe <= 1'b1;
        dqs_out <= ~next_beat[0];
        dqs_oe <= 1'b1;
      end else begin
        beat_reg <= 2'd0;
        burst_beat <= 2'd0;
        dq_out <= 16'h0000;
        dq_oe <= 1'b0;
        dqs_out <= 1'b0;
        dqs_oe <= 1'b0;
      end
      if (unit_state == ST_IDLE && is_mrw) begin
        if (bank_active) begin
          // not allowed with banks open: dropped
          mrw_ignored <= 1'b1;
        end else if (cmd_addr == `MRCU_MR_RESET) begin
          array_undefined <= 1'b1;
          zq_calibrated <= 1'b0;
          for (i = 0; i < `MRCU_MEM_DEPTH; i = i + 1) begin
            mem_reg[i] <= `MRCU_MR_DEFAULT;
          end
        end else if (cmd_addr == `MRCU_MR_ZQ) begin
          if (zq_tied_sync || !zq_code_ok) begin
            mrw_ignored <= 1'b1;
          end else begin
            zq_kind_reg <= zq_kind;
            zq_current_en <= (zq_kind != 2'd3);
          end
        end else if (is_writable(cmd_addr)) begin
          mem_reg[cmd_addr[`MRCU_MEM_AW-1:0]] <= cmd_data;
        end else begin
          mrw_ignored <= 1'b1;
        end
      end
      if (unit_state == ST_RESETTING && tmr_done) begin
        array_undefined <= 1'b0;
      end
      // current path off once calibration ends
      if (unit_state == ST_ZQ_CAL && tmr_done) begin
        zq_current_en <= 1'b0;
        zq_calibrated <= (zq_kind_reg != 2'd3);
      end
    end
  end

endmodule

`default_nettype wire
